// file: rtl/cbcfg_pkg.sv
`default_nettype none
package cbcfg_pkg;

	// configuration byte offsets (dword aligned words carry several fields)
	localparam logic [7:0] CBCFG_OFF_CACHE_LINE  = 8'h0c;
	localparam logic [7:0] CBCFG_OFF_TENURE      = 8'h0d;
	localparam logic [7:0] CBCFG_OFF_HEADER      = 8'h0e;
	localparam logic [7:0] CBCFG_OFF_SELF_TEST   = 8'h0f;
	localparam logic [7:0] CBCFG_OFF_SOCKET_BASE = 8'h10;
	localparam logic [7:0] CBCFG_OFF_CAP_PTR     = 8'h14;
	localparam logic [7:0] CBCFG_OFF_CARD_STAT   = 8'h16;
	localparam logic [7:0] CBCFG_OFF_EXT_FIRST   = 8'h80;

	// reset and fixed values
	localparam logic [7:0]  CBCFG_RST_CACHE_LINE  = 8'h00;
	localparam logic [7:0]  CBCFG_RST_TENURE      = 8'h00;
	localparam logic [7:0]  CBCFG_VAL_HEADER      = 8'h82;
	localparam logic [7:0]  CBCFG_VAL_SELF_TEST   = 8'h00;
	localparam logic [19:0] CBCFG_RST_SOCKET_BASE = 20'h00000;
	localparam logic [7:0]  CBCFG_VAL_CAP_PTR     = 8'ha0;
	localparam logic [15:0] CBCFG_RST_CARD_STAT   = 16'h0200;

	// socket window layout
	localparam int          CBCFG_BASE_LSB   = 12;
	localparam logic [11:0] CBCFG_LEGACY_OFF = 12'h800;

	// card side status field positions
	localparam int CBCFG_ST_PARITY  = 15;
	localparam int CBCFG_ST_SERR    = 14;
	localparam int CBCFG_ST_MABORT  = 13;
	localparam int CBCFG_ST_REC_TA  = 12;
	localparam int CBCFG_ST_SIG_TA  = 11;
	localparam int CBCFG_ST_TIM_LSB = 9;
	localparam int CBCFG_ST_DPAR    = 8;
	localparam logic [1:0]  CBCFG_SELECT_TIMING = 2'b01;
	localparam logic [15:0] CBCFG_CLR_MASK      = 16'hf900;

	// configuration request from the host side decoder
	typedef struct packed {
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cbcfg_req_s;

	// configuration answer
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} cbcfg_rsp_s;

	// card side error events, one-cycle pulses
	typedef struct packed {
		logic parity;
		logic serr;
		logic mabort;
		logic rec_ta;
		logic sig_ta;
		logic dpar;
	} cbcfg_evt_s;

endpackage
`default_nettype wire

// file: rtl/cbcfg_regs.sv
// Summary of operation
// - cache line length register is 8-bit read/write, reset to zero.
// - as initiator, tenure counter starts at zero on frame and counts clocks.
// - once count reaches the limit, end the transaction when grant drops.
// - header layout code always reads 82h.
// - offsets 00h-7Fh are standard header, 80h-FFh are extension registers.
// - no self test; self test register always reads zero.
// - socket base bits 31-12 are writable, placing window on 4K boundary.
// - socket base bits 11-0 are read-only zero.
// - writing all ones to socket base reads back FFFF F000h.
// - socket registers start at 000h, legacy socket registers at 800h.
// - capability pointer is read-only and returns A0h.
// - writing one clears a clearable status bit unless an event sets it in the same cycle; writing zero keeps it.
// - status bits 15-11 and 8 clearable, others read-only; reset 0200h.
// - select timing field bits 10-9 hardwired to 01b.
// - status bit 15 sets on card side address or data parity error.
// - status bit 13 sets on card side master abort of own cycle.
`timescale 1ns/100ps
`default_nettype none
module cbcfg_regs
	import cbcfg_pkg::*;
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	// configuration access
	input  wire cbcfg_req_s  i_cfg,
	output var  cbcfg_rsp_s  o_cfg,
	output logic             o_cfg_ext,
	// initiator tenure
	input  wire logic        i_init_frame_start,
	input  wire logic        i_init_active,
	input  wire logic        i_gnt_n,
	output logic             o_tenure_end,
	output logic [7:0]       o_tenure_count,
	// card side events
	input  wire cbcfg_evt_s  i_evt,
	output logic [15:0]      o_card_status,
	// socket window decode; cache line length out
	input  wire logic        i_mem_enable,
	input  wire logic        i_mem_valid,
	input  wire logic [31:0] i_mem_addr,
	output logic             o_socket_hit,
	output logic             o_legacy_hit,
	output logic [7:0]       o_cache_line
);

	////////////////////////////////////////////////////////////////////////
	// register state

	logic [7:0]  cache_line_reg;
	logic [7:0]  tenure_limit_reg;
	logic [19:0] socket_base_reg;
	logic [15:0] card_stat_reg;
	logic [15:0] card_stat_next;
	logic [7:0]  tenure_cnt_reg;
	logic        tenure_run_reg;
	logic        gnt_meta_reg;
	logic        gnt_n_reg;
	cbcfg_rsp_s  rsp_reg;
	logic        ext_reg;
	logic [31:0] rdata_next;
	logic [5:0]  dw;
	logic        wr;
	logic [15:0] stat_set;
	logic [15:0] stat_clr;

	assign dw = i_cfg.addr[7:2];
	assign wr = i_cfg.req & i_cfg.we;

	////////////////////////////////////////////////////////////////////////
	// cache line length and tenure limit share the dword at 0ch

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cache_line_reg   <= CBCFG_RST_CACHE_LINE;
			tenure_limit_reg <= CBCFG_RST_TENURE;
		end else if (wr && dw == CBCFG_OFF_CACHE_LINE[7:2]) begin
			if (i_cfg.be[0])
				cache_line_reg <= i_cfg.wdata[7:0];
			if (i_cfg.be[1])
				tenure_limit_reg <= i_cfg.wdata[15:8];
			// header and self test lanes are read-only, writes dropped
		end
	end

	// socket window base: only the upper twenty bits hold state
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			socket_base_reg <= CBCFG_RST_SOCKET_BASE;
		end else if (wr && dw == CBCFG_OFF_SOCKET_BASE[7:2]) begin
			if (i_cfg.be[1])
				socket_base_reg[3:0] <= i_cfg.wdata[15:12];
			if (i_cfg.be[2])
				socket_base_reg[11:4] <= i_cfg.wdata[23:16];
			if (i_cfg.be[3])
				socket_base_reg[19:12] <= i_cfg.wdata[31:24];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// card side status: events set, ones written clear, set wins

	always_comb begin
		stat_set = 16'h0000;
		stat_set[CBCFG_ST_PARITY] = i_evt.parity;
		stat_set[CBCFG_ST_SERR]   = i_evt.serr;
		stat_set[CBCFG_ST_MABORT] = i_evt.mabort;
		stat_set[CBCFG_ST_REC_TA] = i_evt.rec_ta;
		stat_set[CBCFG_ST_SIG_TA] = i_evt.sig_ta;
		stat_set[CBCFG_ST_DPAR]   = i_evt.dpar;
		stat_clr = 16'h0000;
		if (wr && dw == CBCFG_OFF_CARD_STAT[7:2]) begin
			stat_clr[7:0]  = i_cfg.be[2] ? i_cfg.wdata[23:16] : 8'h00;
			stat_clr[15:8] = i_cfg.be[3] ? i_cfg.wdata[31:24] : 8'h00;
		end
		// only clearable bits react; timing field stays fixed
		card_stat_next = ((card_stat_reg & ~(stat_clr & CBCFG_CLR_MASK))
			| (stat_set & CBCFG_CLR_MASK));
		card_stat_next[CBCFG_ST_TIM_LSB+1:CBCFG_ST_TIM_LSB] =
			CBCFG_SELECT_TIMING;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			card_stat_reg <= CBCFG_RST_CARD_STAT;
		else
			card_stat_reg <= card_stat_next;
	end

	////////////////////////////////////////////////////////////////////////
	// read mux and answer; one cycle after the request

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (dw == CBCFG_OFF_CACHE_LINE[7:2]) begin
			rdata_next = {CBCFG_VAL_SELF_TEST, CBCFG_VAL_HEADER,
				tenure_limit_reg, cache_line_reg};
		end else if (dw == CBCFG_OFF_SOCKET_BASE[7:2]) begin
			rdata_next = {socket_base_reg, 12'h000};
		end else if (dw == CBCFG_OFF_CAP_PTR[7:2]) begin
			rdata_next = {card_stat_reg, 8'h00, CBCFG_VAL_CAP_PTR};
		end else begin
			rdata_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rsp_reg <= '0;
			ext_reg <= 1'b0;
		end else begin
			rsp_reg.ack <= i_cfg.req;
			if (i_cfg.req)
				rsp_reg.rdata <= rdata_next;
			// upper half belongs to the extension logic elsewhere
			ext_reg <= i_cfg.req & (i_cfg.addr >= CBCFG_OFF_EXT_FIRST);
		end
	end

	assign o_cfg     = rsp_reg;
	assign o_cfg_ext = ext_reg;

	////////////////////////////////////////////////////////////////////////
	// grant pin synchroniser; first stage read only by the second

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gnt_meta_reg <= 1'b1;
			gnt_n_reg    <= 1'b1;
		end else begin
			gnt_meta_reg <= i_gnt_n;
			gnt_n_reg    <= gnt_meta_reg;
		end
	end

	// tenure counter saturates so a long burst cannot wrap past the limit
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tenure_cnt_reg <= 8'h00;
			tenure_run_reg <= 1'b0;
		end else if (i_init_frame_start) begin
			tenure_cnt_reg <= 8'h00;
			tenure_run_reg <= 1'b1;
		end else if (!i_init_active) begin
			tenure_run_reg <= 1'b0;
		end else if (tenure_run_reg && tenure_cnt_reg != 8'hff) begin
			tenure_cnt_reg <= tenure_cnt_reg + 8'h01;
		end
	end

	// end request while expired and grant withdrawn
	assign o_tenure_end = tenure_run_reg & i_init_active & ~i_init_frame_start
		& (tenure_cnt_reg >= tenure_limit_reg) & gnt_n_reg;
	assign o_tenure_count = tenure_cnt_reg;

	////////////////////////////////////////////////////////////////////////
	// socket window decode, 4 Kbyte window split at the legacy offset

	assign o_socket_hit = i_mem_enable & i_mem_valid
		& (i_mem_addr[31:CBCFG_BASE_LSB] == socket_base_reg);
	assign o_legacy_hit = o_socket_hit
		& (i_mem_addr[CBCFG_BASE_LSB-1:0] >= CBCFG_LEGACY_OFF);
	assign o_card_status = card_stat_reg;
	assign o_cache_line  = cache_line_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_full_write;
		i_cfg.req && i_cfg.we && i_cfg.addr[7:2] == 6'h04 && i_cfg.be == 4'hf
			&& i_cfg.wdata == 32'hffff_ffff;
	endsequence

	sequence s_read_base;
		i_cfg.req && !i_cfg.we && i_cfg.addr[7:2] == 6'h04;
	endsequence

	property p_size_readback;
		@(posedge i_mclk) disable iff (!i_reset_n)
		s_full_write ##1 !wr ##1 s_read_base
			|=> o_cfg.rdata == 32'hffff_f000;
	endproperty
	a_size_readback: assert property (p_size_readback)
		else $error("socket base sizing readback wrong");

	property p_low_zero;
		@(posedge i_mclk) disable iff (!i_reset_n)
		s_read_base |=> o_cfg.rdata[11:0] == 12'h000;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("socket base low bits not zero");

	property p_header;
		@(posedge i_mclk) disable iff (!i_reset_n)
		i_cfg.req && i_cfg.addr[7:2] == 6'h03
			|=> o_cfg.ack && o_cfg.rdata[31:16] == 16'h0082;
	endproperty
	a_header: assert property (p_header)
		else $error("header or self test value wrong");

	property p_cap_ptr;
		@(posedge i_mclk) disable iff (!i_reset_n)
		i_cfg.req && i_cfg.addr[7:2] == 6'h05 |=> o_cfg.rdata[7:0] == 8'ha0;
	endproperty
	a_cap_ptr: assert property (p_cap_ptr)
		else $error("capability pointer wrong");

	property p_parity_set;
		@(posedge i_mclk) disable iff (!i_reset_n)
		i_evt.parity |=> card_stat_reg[15];
	endproperty
	a_parity_set: assert property (p_parity_set)
		else $error("parity flag not set");

	property p_mabort_set;
		@(posedge i_mclk) disable iff (!i_reset_n)
		i_evt.mabort |=> card_stat_reg[13];
	endproperty
	a_mabort_set: assert property (p_mabort_set)
		else $error("master abort flag not set");

	property p_clear_one;
		@(posedge i_mclk) disable iff (!i_reset_n)
		wr && dw == 6'h05 && i_cfg.be[3] && i_cfg.wdata[29]
			&& card_stat_reg[13] && !i_evt.mabort |=> !card_stat_reg[13];
	endproperty
	a_clear_one: assert property (p_clear_one)
		else $error("write one did not clear status");

	property p_keep_zero;
		@(posedge i_mclk) disable iff (!i_reset_n)
		card_stat_reg[15] && !(wr && dw == 6'h05 && i_cfg.be[3]
			&& i_cfg.wdata[31]) |=> card_stat_reg[15];
	endproperty
	a_keep_zero: assert property (p_keep_zero)
		else $error("status bit lost without a clear");

	property p_fixed_bits;
		@(posedge i_mclk) disable iff (!i_reset_n)
		1'b1 |=> card_stat_reg[10:9] == 2'b01 && card_stat_reg[7:0] == 8'h00;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("read-only status bits changed");

	property p_count_start;
		@(posedge i_mclk) disable iff (!i_reset_n)
		i_init_frame_start ##1 (i_init_active && !i_init_frame_start)
			|=> tenure_cnt_reg == 8'h01;
	endproperty
	a_count_start: assert property (p_count_start)
		else $error("tenure counter did not start from zero");

	property p_end_needs_gnt;
		@(posedge i_mclk) disable iff (!i_reset_n)
		o_tenure_end |-> gnt_n_reg && tenure_cnt_reg >= tenure_limit_reg;
	endproperty
	a_end_needs_gnt: assert property (p_end_needs_gnt)
		else $error("tenure end without expiry and grant loss");

	property p_cache_write;
		@(posedge i_mclk) disable iff (!i_reset_n)
		wr && dw == 6'h03 && i_cfg.be[0]
			|=> cache_line_reg == $past(i_cfg.wdata[7:0]);
	endproperty
	a_cache_write: assert property (p_cache_write)
		else $error("cache line length not stored");

	property p_legacy;
		@(posedge i_mclk) disable iff (!i_reset_n)
		o_legacy_hit |-> o_socket_hit && i_mem_addr[11];
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("legacy decode outside upper half");

endmodule // cbcfg_regs
`default_nettype wire

// file: sim/cbcfg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbcfg_host_model
	import cbcfg_pkg::*;
(
	// clock
	input  wire logic        i_mclk,
	// configuration port
	output var  cbcfg_req_s  o_cfg,
	input  wire cbcfg_rsp_s  i_cfg,
	input  wire logic        i_cfg_ext
);

	logic ext_seen;

	initial begin
		o_cfg = '0;
		ext_seen = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one configuration cycle, driven on falling edges; sizing and base
	// programming order is left to the caller
	task automatic access(input logic we, input logic [7:0] addr,
		input logic [3:0] be, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic ack);
		@(negedge i_mclk);
		o_cfg.req = 1'b1;
		o_cfg.we = we;
		o_cfg.addr = addr;
		o_cfg.be = be;
		o_cfg.wdata = wdata;
		@(negedge i_mclk);
		// ack and ext stand only until the next edge, so take the answer
		// here, before the request drops
		rdata = i_cfg.rdata;
		ack = i_cfg.ack;
		ext_seen = i_cfg_ext;
		// released lines never keep the old value
		o_cfg.req = 1'b0;
		o_cfg.we = ~we;
		o_cfg.addr = ~addr;
		o_cfg.be = ~be;
		o_cfg.wdata = ~wdata;
	endtask

endmodule // cbcfg_host_model
`default_nettype wire

// file: sim/cbcfg_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cbcfg_regs_tb_top
	import cbcfg_pkg::*;
;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	cbcfg_req_s  cfg_req;
	cbcfg_rsp_s  cfg_rsp;
	logic        cfg_ext;
	logic        frame_start = 1'b0;
	logic        active = 1'b0;
	logic        gnt_n = 1'b0;
	logic        tenure_end;
	logic [7:0]  tenure_count;
	cbcfg_evt_s  evt = '0;
	logic [15:0] card_status;
	logic        mem_enable = 1'b0;
	logic        mem_valid = 1'b1;
	logic [31:0] mem_addr = 32'h0;
	logic        socket_hit;
	logic        legacy_hit;
	logic [7:0]  cache_line;
	int          n_errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	logic [15:0] st_exp;

	// 10 MHz clock
	always #50 mclk = ~mclk;

	cbcfg_regs u_cbcfg_regs (
		.i_mclk(mclk), .i_reset_n(reset_n), .i_cfg(cfg_req), .o_cfg(cfg_rsp),
		.o_cfg_ext(cfg_ext), .i_init_frame_start(frame_start),
		.i_init_active(active), .i_gnt_n(gnt_n), .o_tenure_end(tenure_end),
		.o_tenure_count(tenure_count), .i_evt(evt),
		.o_card_status(card_status), .i_mem_enable(mem_enable),
		.i_mem_valid(mem_valid), .i_mem_addr(mem_addr),
		.o_socket_hit(socket_hit), .o_legacy_hit(legacy_hit),
		.o_cache_line(cache_line));

	cbcfg_host_model u_cbcfg_host_model (
		.i_mclk(mclk), .o_cfg(cfg_req), .i_cfg(cfg_rsp), .i_cfg_ext(cfg_ext));

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		logic [31:0] r;
		logic k;
		u_cbcfg_host_model.access(1'b1, a, be, d, r, k);
		chk({31'h0, k}, 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic k;
		u_cbcfg_host_model.access(1'b0, a, 4'hf, 32'h0, r, k);
		chk({31'h0, k}, 32'h1);
		chk(r, exp);
	endtask

	// decode is combinational, so look just after driving the address
	task automatic dec(input logic [31:0] a, input logic h, input logic l);
		@(negedge mclk);
		mem_addr = a;
		#1;
		chk({30'h0, socket_hit, legacy_hit}, {30'h0, h, l});
	endtask

	// hang guard, far above the length of the sequence
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge mclk);
		reset_n = 1'b1;
		rd(CBCFG_OFF_CACHE_LINE, 32'h0082_0000);
		rd(CBCFG_OFF_SOCKET_BASE, 32'h0);
		rd(CBCFG_OFF_CAP_PTR, 32'h0200_00a0);
		wr(CBCFG_OFF_CACHE_LINE, 4'hf, 32'hffff_ffff);
		rd(CBCFG_OFF_CACHE_LINE, 32'h0082_ffff);
		chk({24'h0, cache_line}, 32'hff);
		wr(CBCFG_OFF_CACHE_LINE, 4'h2, 32'h0000_0300);
		rd(CBCFG_OFF_CACHE_LINE, 32'h0082_03ff);
		// unmapped and extension space read zero
		rd(8'h18, 32'h0);
		chk({31'h0, u_cbcfg_host_model.ext_seen}, 32'h0);
		wr(CBCFG_OFF_EXT_FIRST, 4'hf, 32'hffff_ffff);
		rd(CBCFG_OFF_EXT_FIRST, 32'h0);
		chk({31'h0, u_cbcfg_host_model.ext_seen}, 32'h1);
		// size the window before decode is enabled
		wr(CBCFG_OFF_SOCKET_BASE, 4'hf, 32'hffff_ffff);
		rd(CBCFG_OFF_SOCKET_BASE, 32'hffff_f000);
		wr(CBCFG_OFF_SOCKET_BASE, 4'hf, 32'h1234_5678);
		rd(CBCFG_OFF_SOCKET_BASE, 32'h1234_5000);
		mem_enable = 1'b1;
		dec(32'h1234_5004, 1'b1, 1'b0);
		dec(32'h1234_57ff, 1'b1, 1'b0);
		dec(32'h1234_5800, 1'b1, 1'b1);
		dec(32'h1234_6000, 1'b0, 1'b0);
		@(negedge mclk);
		mem_valid = 1'b0;
		dec(32'h1234_5004, 1'b0, 1'b0);
		@(negedge mclk);
		mem_valid = 1'b1;
		mem_enable = 1'b0;
		dec(32'h1234_5800, 1'b0, 1'b0);
		// tenure: limit 3, grant held, then grant dropped
		@(negedge mclk);
		frame_start = 1'b1;
		active = 1'b1;
		@(negedge mclk);
		frame_start = 1'b0;
		chk({24'h0, tenure_count}, 32'h0);
		repeat (3) @(negedge mclk);
		chk({24'h0, tenure_count}, 32'h3);
		chk({31'h0, tenure_end}, 32'h0);
		gnt_n = 1'b1;
		repeat (3) @(negedge mclk);
		chk({31'h0, tenure_end}, 32'h1);
		active = 1'b0;
		@(negedge mclk);
		chk({31'h0, tenure_end}, 32'h0);
		// each card side event sets its own bit
		st_exp = 16'h0200;
		for (int k = 0; k < 6; k++) begin
			@(negedge mclk);
			evt = cbcfg_evt_s'(6'b100000 >> k);
			@(negedge mclk);
			evt = '0;
			st_exp |= (k == 5) ? 16'h0100 : (16'h8000 >> k);
			chk({16'h0, card_status}, {16'h0, st_exp});
		end
		wr(CBCFG_OFF_CAP_PTR, 4'hc, 32'h0);
		rd(CBCFG_OFF_CAP_PTR, 32'hfb00_00a0);
		wr(CBCFG_OFF_CAP_PTR, 4'hc, 32'h8000_0000);
		rd(CBCFG_OFF_CAP_PTR, 32'h7b00_00a0);
		wr(CBCFG_OFF_CAP_PTR, 4'hf, 32'h06ff_ffff);
		rd(CBCFG_OFF_CAP_PTR, 32'h7b00_00a0);
		wr(CBCFG_OFF_CAP_PTR, 4'hc, 32'hffff_0000);
		rd(CBCFG_OFF_CAP_PTR, 32'h0200_00a0);
		// reset in mid-run restores defaults
		@(negedge mclk);
		evt = cbcfg_evt_s'(6'b001000);
		@(negedge mclk);
		evt = '0;
		reset_n = 1'b0;
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		chk({16'h0, card_status}, 32'h0200);
		rd(CBCFG_OFF_CACHE_LINE, 32'h0082_0000);
		rd(CBCFG_OFF_SOCKET_BASE, 32'h0);
		close_out();
	end

endmodule // cbcfg_regs_tb_top
`default_nettype wire
